// ### hdl/mpsfr_pkg.sv
// Package of constants for the power-mode and function-register-space block.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package mpsfr_pkg;
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam int SFR_SIZE = 128;
    localparam logic [7:0] BITMEM_BASE = 8'h20;
    localparam int BITMEM_SIZE = 16;
    localparam logic [7:0] ADDR_STACK = 8'h81;
    localparam logic [7:0] ADDR_PTR_LO = 8'h82;
    localparam logic [7:0] ADDR_PTR_HI = 8'h83;
    localparam logic [7:0] ADDR_POWER = 8'h87;
    localparam logic [7:0] ADDR_T0_LO = 8'h8a;
    localparam logic [7:0] ADDR_T1_LO = 8'h8b;
    localparam logic [7:0] ADDR_T0_HI = 8'h8c;
    localparam logic [7:0] ADDR_T1_HI = 8'h8d;
    localparam logic [7:0] ADDR_PORT0 = 8'h80;
    localparam logic [7:0] ADDR_PORT1 = 8'h90;
    localparam logic [7:0] ADDR_PORT2 = 8'ha0;
    localparam logic [7:0] ADDR_PORT3 = 8'hb0;
    localparam logic [7:0] ADDR_PRIO = 8'hb8;
    localparam logic [7:0] ADDR_STATUS = 8'hd0;
    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] PRIO_MASK = 8'h1f;
    localparam logic [7:0] POWER_MASK = 8'h8f;
    localparam int POWER_DOZE = 0;
    localparam int POWER_DEEP = 1;
    localparam int POWER_GF0 = 2;
    localparam int POWER_GF1 = 3;
    localparam int POWER_DOUBLE = 7;
    localparam int STATUS_PARITY = 0;
    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_DOZE = 2'b01,
        MODE_DEEP = 2'b10,
        MODE_EMUL = 2'b11
    } mpsfr_mode_type;
endpackage : mpsfr_pkg

// ### hdl/mpsfr_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes pins are asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module mpsfr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage_reg;
    generate
        if (WIDTH < 1) begin : g_width_check
            $error("mpsfr_sync needs a WIDTH of one or more");
        end
    endgenerate
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stage_reg <= '0;
            q <= '0;
        end else begin
            stage_reg <= d;
            q <= stage_reg;
        end
    end
endmodule : mpsfr_sync
`default_nettype wire

// ### hdl/mpsfr_top.sv
// Power-mode control and function register space of an 8-bit controller.
// Assumes one 100 MHz clock, asynchronous low reset, pins passed as in/out/oe.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Function registers occupy 128 bytes from 80H
// - Upper region: direct hits registers, indirect memory
// - Addresses ending x0H/x8H are bit addressable
// - Unimplemented register addresses store nothing
// - Sixteen bit-addressable bytes above register banks
// - Stack pointer resets to 07H
// - Data pointer accessible as word or bytes
// - Input port latch ANDs in sampled pin state, except in deep sleep
// - Two timers count in high/low byte pairs
// - Priority holds five bits; three reserved
// - Status word carries flags, bank bits, parity
// - Power register: sleep, doze, double, flags
// - Deep sleep stops oscillator (CMOS variant only), holds strobes low
// - Reset exits deep sleep, memory kept
// - Doze gates CPU clock, strobes high
// - Enabled interrupt clears doze bit
// - Hardware reset ends doze
// - Strobe low through reset enters emulation
// - Emulation floats port 0, strobes weak high
// - Writing one to sleep bit stops oscillator (CMOS variant, not in emulation)
// - Internal clock taken from selected crystal pin
module mpsfr_top #(
    parameter bit CMOS_VARIANT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_indirect,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic bit_write,
    input wire logic [2:0] bit_index,
    input wire logic bit_value,
    input wire logic ptr_word_write,
    input wire logic [15:0] ptr_word_wdata,
    output logic [15:0] data_address_pointer,
    input wire logic [7:0] status_wdata,
    input wire logic status_write,
    input wire logic [7:0] accum_value,
    input wire logic [4:0] irq_pending,
    input wire logic [4:0] irq_enable,
    output logic irq_wake,
    input wire logic [1:0] timer_tick,
    input wire logic [31:0] port_pins_in,
    output logic [31:0] port_pins_out,
    output logic [31:0] port_pins_oe,
    input wire logic reset_pin,
    input wire logic crystal_input_pin,
    input wire logic crystal_output_pin,
    output logic osc_enable,
    output logic cpu_clock_enable,
    output logic periph_clock_enable,
    output logic clock_source,
    output logic in_circuit_emulation_mode,
    input wire logic addr_latch_in,
    output logic addr_latch_out,
    output logic addr_latch_oe,
    output logic addr_latch_weak,
    input wire logic program_fetch_strobe_in,
    output logic program_fetch_strobe_out,
    output logic program_fetch_strobe_oe,
    output logic program_fetch_strobe_weak,
    input wire logic cpu_ale,
    input wire logic cpu_fetch
);
    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic in_sfr(input logic [7:0] a);
        in_sfr = a[7];
    endfunction : in_sfr

    function automatic logic bit_addressable(input logic [7:0] a);
        bit_addressable = in_sfr(a) && (a[2:0] == 3'h0);
    endfunction : bit_addressable

    function automatic logic [7:0] merge_bit(input logic [7:0] old, input logic [2:0] idx,
                                             input logic val);
        logic [7:0] r;
        r = old;
        r[idx] = val;
        merge_bit = r;
    endfunction : merge_bit

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [31:0] pins_sync;
    logic rst_pin_sync;
    logic ale_pin_sync;
    logic fetch_pin_sync;
    logic [34:0] sync_q;

    // Idle-high pins stored inverted so reset matches their idle level
    mpsfr_sync #(.WIDTH(35)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d({~port_pins_in, reset_pin, ~addr_latch_in, ~program_fetch_strobe_in}),
        .q(sync_q)
    );
    assign pins_sync = ~sync_q[34:3];
    assign rst_pin_sync = sync_q[2];
    assign ale_pin_sync = ~sync_q[1];
    assign fetch_pin_sync = ~sync_q[0];

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] stack_top_pointer;
    logic [7:0] program_status_word;
    logic [7:0] interrupt_priority_reg;
    logic [7:0] power_control_reg;
    logic [7:0] port_latch_reg [4];
    logic [15:0] timer_reg [2];
    logic [7:0] bitmem_reg [mpsfr_pkg::BITMEM_SIZE];
    logic [7:0] upper_mem_reg [mpsfr_pkg::SFR_SIZE];
    mpsfr_pkg::mpsfr_mode_type mode_reg;
    logic rst_seen_reg;
    logic ale_low_in_reset_reg;
    logic [7:0] rdata_next;

    wire direct_wr = reg_write && !reg_indirect;
    wire indirect_wr = reg_write && reg_indirect && in_sfr(reg_addr);
    wire bit_wr = bit_write && bit_addressable(reg_addr) && !reg_indirect;
    wire hw_reset = rst_pin_sync;

    function automatic logic [7:0] wval(input logic [7:0] old);
        wval = bit_wr ? merge_bit(old, bit_index, bit_value) : reg_wdata;
    endfunction : wval

    function automatic logic hit(input logic [7:0] a);
        hit = (direct_wr || bit_wr) && (reg_addr == a);
    endfunction : hit

    // ------------------------------------------------------------
    // Stack pointer and data pointer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stack_top_pointer <= mpsfr_pkg::STACK_RESET;
        end else if (hw_reset) begin
            stack_top_pointer <= mpsfr_pkg::STACK_RESET;
        end else if (hit(mpsfr_pkg::ADDR_STACK)) begin
            stack_top_pointer <= wval(stack_top_pointer);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            data_address_pointer <= 16'h0000;
        end else if (hw_reset) begin
            data_address_pointer <= 16'h0000;
        end else if (ptr_word_write) begin
            data_address_pointer <= ptr_word_wdata;
        end else if (hit(mpsfr_pkg::ADDR_PTR_LO)) begin
            data_address_pointer[7:0] <= wval(data_address_pointer[7:0]);
        end else if (hit(mpsfr_pkg::ADDR_PTR_HI)) begin
            data_address_pointer[15:8] <= wval(data_address_pointer[15:8]);
        end
    end

    // ------------------------------------------------------------
    // Status word, priority, power control
    // ------------------------------------------------------------
    wire [7:0] status_merged = wval(program_status_word);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            program_status_word <= 8'h00;
        end else if (hw_reset) begin
            program_status_word <= 8'h00;
        end else if (status_write) begin
            program_status_word[7:1] <= status_wdata[7:1];
            program_status_word[mpsfr_pkg::STATUS_PARITY] <= ^accum_value;
        end else if (hit(mpsfr_pkg::ADDR_STATUS)) begin
            program_status_word[7:1] <= status_merged[7:1];
            program_status_word[mpsfr_pkg::STATUS_PARITY] <= ^accum_value;
        end else begin
            program_status_word[mpsfr_pkg::STATUS_PARITY] <= ^accum_value;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            interrupt_priority_reg <= 8'h00;
        end else if (hw_reset) begin
            interrupt_priority_reg <= 8'h00;
        end else if (hit(mpsfr_pkg::ADDR_PRIO)) begin
            interrupt_priority_reg <= wval(interrupt_priority_reg) & mpsfr_pkg::PRIO_MASK;
        end
    end

    wire any_irq = |(irq_pending & irq_enable);
    assign irq_wake = (mode_reg == mpsfr_pkg::MODE_DOZE) && any_irq;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            power_control_reg <= 8'h00;
        end else if (hw_reset) begin
            power_control_reg <= 8'h00;
        end else if (mode_reg == mpsfr_pkg::MODE_DEEP) begin
            power_control_reg <= power_control_reg;
        end else if (hit(mpsfr_pkg::ADDR_POWER)) begin
            power_control_reg <= wval(power_control_reg) & mpsfr_pkg::POWER_MASK;
        end else if (any_irq) begin
            power_control_reg[mpsfr_pkg::POWER_DOZE] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Port latches and timers
    // ------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_port
            localparam logic [7:0] PADDR = 8'h80 + 8'(gp * 16);
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    port_latch_reg[gp] <= mpsfr_pkg::PORT_RESET;
                end else if (hw_reset) begin
                    port_latch_reg[gp] <= mpsfr_pkg::PORT_RESET;
                end else if (hit(PADDR)) begin
                    port_latch_reg[gp] <= wval(port_latch_reg[gp]);
                end else if (mode_reg != mpsfr_pkg::MODE_DEEP) begin
                    port_latch_reg[gp] <= port_latch_reg[gp] & pins_sync[gp*8 +: 8];
                end
            end
            assign port_pins_out[gp*8 +: 8] = port_latch_reg[gp];
            assign port_pins_oe[gp*8 +: 8] = (gp == 0 && mode_reg == mpsfr_pkg::MODE_EMUL) ?
                8'h00 : ~port_latch_reg[gp];
        end
    endgenerate

    genvar gt;
    generate
        for (gt = 0; gt < 2; gt++) begin : g_timer
            localparam logic [7:0] LADDR = gt == 0 ? mpsfr_pkg::ADDR_T0_LO : mpsfr_pkg::ADDR_T1_LO;
            localparam logic [7:0] HADDR = gt == 0 ? mpsfr_pkg::ADDR_T0_HI : mpsfr_pkg::ADDR_T1_HI;
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    timer_reg[gt] <= 16'h0000;
                end else if (hw_reset) begin
                    timer_reg[gt] <= 16'h0000;
                end else if (hit(LADDR)) begin
                    timer_reg[gt][7:0] <= wval(timer_reg[gt][7:0]);
                end else if (hit(HADDR)) begin
                    timer_reg[gt][15:8] <= wval(timer_reg[gt][15:8]);
                end else if (timer_tick[gt] && mode_reg != mpsfr_pkg::MODE_DEEP) begin
                    timer_reg[gt] <= timer_reg[gt] + 16'h0001;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Internal memory: bit block and indirect upper half
    // ------------------------------------------------------------
    genvar gm;
    generate
        for (gm = 0; gm < mpsfr_pkg::BITMEM_SIZE; gm++) begin : g_bitmem
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    bitmem_reg[gm] <= 8'h00;
                end else if (bit_write && reg_addr == mpsfr_pkg::BITMEM_BASE + 8'(gm)) begin
                    bitmem_reg[gm] <= merge_bit(bitmem_reg[gm], bit_index, bit_value);
                end else if (reg_write && reg_addr == mpsfr_pkg::BITMEM_BASE + 8'(gm)) begin
                    bitmem_reg[gm] <= reg_wdata;
                end
            end
        end
        for (gm = 0; gm < mpsfr_pkg::SFR_SIZE; gm++) begin : g_upper
            always_ff @(posedge clk_sys) begin
                if (indirect_wr && reg_addr[6:0] == 7'(gm)) begin
                    upper_mem_reg[gm] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (reg_indirect && in_sfr(reg_addr)) begin
            rdata_next = upper_mem_reg[reg_addr[6:0]];
        end else if (reg_addr >= mpsfr_pkg::BITMEM_BASE &&
                     reg_addr < mpsfr_pkg::BITMEM_BASE + 8'(mpsfr_pkg::BITMEM_SIZE)) begin
            rdata_next = bitmem_reg[reg_addr[3:0]];
        end else begin
            case (reg_addr)
                mpsfr_pkg::ADDR_STACK: rdata_next = stack_top_pointer;
                mpsfr_pkg::ADDR_PTR_LO: rdata_next = data_address_pointer[7:0];
                mpsfr_pkg::ADDR_PTR_HI: rdata_next = data_address_pointer[15:8];
                mpsfr_pkg::ADDR_POWER: rdata_next = power_control_reg;
                mpsfr_pkg::ADDR_T0_LO: rdata_next = timer_reg[0][7:0];
                mpsfr_pkg::ADDR_T0_HI: rdata_next = timer_reg[0][15:8];
                mpsfr_pkg::ADDR_T1_LO: rdata_next = timer_reg[1][7:0];
                mpsfr_pkg::ADDR_T1_HI: rdata_next = timer_reg[1][15:8];
                mpsfr_pkg::ADDR_PORT0: rdata_next = port_latch_reg[0];
                mpsfr_pkg::ADDR_PORT1: rdata_next = port_latch_reg[1];
                mpsfr_pkg::ADDR_PORT2: rdata_next = port_latch_reg[2];
                mpsfr_pkg::ADDR_PORT3: rdata_next = port_latch_reg[3];
                mpsfr_pkg::ADDR_PRIO: rdata_next = interrupt_priority_reg;
                mpsfr_pkg::ADDR_STATUS: rdata_next = program_status_word;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_seen_reg <= 1'b0;
            ale_low_in_reset_reg <= 1'b0;
        end else begin
            rst_seen_reg <= hw_reset;
            if (hw_reset) begin
                ale_low_in_reset_reg <= !ale_pin_sync && fetch_pin_sync;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= mpsfr_pkg::MODE_RUN;
        end else if (hw_reset) begin
            mode_reg <= mpsfr_pkg::MODE_RUN;
        end else if (rst_seen_reg && ale_low_in_reset_reg && !ale_pin_sync) begin
            mode_reg <= mpsfr_pkg::MODE_EMUL;
        end else begin
            case (mode_reg)
                mpsfr_pkg::MODE_RUN: begin
                    if (power_control_reg[mpsfr_pkg::POWER_DEEP]) begin
                        mode_reg <= mpsfr_pkg::MODE_DEEP;
                    end else if (power_control_reg[mpsfr_pkg::POWER_DOZE]) begin
                        mode_reg <= mpsfr_pkg::MODE_DOZE;
                    end
                end
                mpsfr_pkg::MODE_DOZE: begin
                    if (power_control_reg[mpsfr_pkg::POWER_DEEP]) begin
                        mode_reg <= mpsfr_pkg::MODE_DEEP;
                    end else if (!power_control_reg[mpsfr_pkg::POWER_DOZE]) begin
                        mode_reg <= mpsfr_pkg::MODE_RUN;
                    end
                end
                mpsfr_pkg::MODE_DEEP: mode_reg <= mpsfr_pkg::MODE_DEEP;
                mpsfr_pkg::MODE_EMUL: mode_reg <= mpsfr_pkg::MODE_EMUL;
                default: mode_reg <= mpsfr_pkg::MODE_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clock gating and strobe pins
    // ------------------------------------------------------------
    wire deep = mode_reg == mpsfr_pkg::MODE_DEEP;
    wire doze = mode_reg == mpsfr_pkg::MODE_DOZE;
    wire emul = mode_reg == mpsfr_pkg::MODE_EMUL;

    assign osc_enable = !(deep && CMOS_VARIANT);
    assign cpu_clock_enable = !deep && !doze && !emul;
    assign periph_clock_enable = !deep;
    assign clock_source = CMOS_VARIANT ? crystal_input_pin : crystal_output_pin;
    assign in_circuit_emulation_mode = emul;

    assign addr_latch_out = deep ? 1'b0 : (doze ? 1'b1 : cpu_ale);
    assign program_fetch_strobe_out = deep ? 1'b0 : (doze ? 1'b1 : cpu_fetch);
    assign addr_latch_oe = !emul && !hw_reset;
    assign program_fetch_strobe_oe = !emul && !hw_reset;
    assign addr_latch_weak = emul;
    assign program_fetch_strobe_weak = emul;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_deep_strobes_low: assert property (@(posedge clk_sys) disable iff (!resetn)
        deep |-> !addr_latch_out && !program_fetch_strobe_out && !osc_enable == CMOS_VARIANT)
        else $error("strobes not low in deep sleep");
    a_doze_strobes_high: assert property (@(posedge clk_sys) disable iff (!resetn)
        doze |-> addr_latch_out && program_fetch_strobe_out && !cpu_clock_enable)
        else $error("doze pin state wrong");
    a_doze_irq_wake: assert property (@(posedge clk_sys) disable iff (!resetn)
        doze && any_irq && !hw_reset && !hit(mpsfr_pkg::ADDR_POWER) |=> ##1 !doze)
        else $error("interrupt did not end doze");
    a_stack_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
        hw_reset |=> stack_top_pointer == 8'h07)
        else $error("stack pointer not 07H");
    a_reset_ends_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
        hw_reset |=> mode_reg == mpsfr_pkg::MODE_RUN)
        else $error("reset did not end mode");
    a_prio_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
        interrupt_priority_reg[7:5] == 3'h0)
        else $error("priority reserved bits set");
    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_read && !reg_indirect && reg_addr == 8'hff |=> reg_rdata == 8'h00)
        else $error("unmapped address returned data");
    a_emul_port_float: assert property (@(posedge clk_sys) disable iff (!resetn)
        emul |-> port_pins_oe[7:0] == 8'h00 && addr_latch_weak && osc_enable)
        else $error("emulation pins wrong");
endmodule : mpsfr_top
`default_nettype wire

// ### bench/mpsfr_partner.sv
// Reset circuit, crystal and emulator pod facing the block.
// Assumes the bench asks for hardware resets and for emulation entry.
`timescale 1ns/1ns
`default_nettype none
module mpsfr_partner (
    input wire logic hw_rst,
    input wire logic emul,
    input wire logic osc_enable,
    input wire logic addr_latch_oe,
    input wire logic addr_latch_out,
    output logic reset_pin,
    output logic crystal_input_pin,
    output logic crystal_output_pin,
    output logic addr_latch_in,
    output logic program_fetch_strobe_in
);
    assign reset_pin = hw_rst;
    initial crystal_input_pin = 1'b0;
    always #7 if (osc_enable) crystal_input_pin = ~crystal_input_pin;
    assign crystal_output_pin = ~crystal_input_pin;
    // Pod pulls strobe low, else pull-up or device level
    assign addr_latch_in = emul ? 1'b0 : (addr_latch_oe ? addr_latch_out : 1'b1);
    assign program_fetch_strobe_in = 1'b1;
endmodule : mpsfr_partner
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the power-mode and register-space block.
// Assumes the partner model on the pin side.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_sys = 0, resetn = 0, reg_indirect = 0, reg_write = 0, reg_read = 0;
    logic bit_write = 0, bit_value = 0, ptr_word_write = 0, status_write = 0;
    logic cpu_ale = 1, cpu_fetch = 1, hw_rst = 0, emul = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, status_wdata = 0, accum_value = 0;
    logic [2:0] bit_index = 0;
    logic [4:0] irq_pending = 0, irq_enable = 0;
    logic [1:0] timer_tick = 0;
    logic [15:0] ptr_word_wdata = 0, data_address_pointer;
    logic [31:0] port_pins_in = '1, port_pins_out, port_pins_oe;
    logic irq_wake, osc_enable, cpu_clock_enable, periph_clock_enable, clock_source;
    logic in_circuit_emulation_mode, addr_latch_out, addr_latch_oe, addr_latch_weak;
    logic program_fetch_strobe_out, program_fetch_strobe_oe, program_fetch_strobe_weak;
    logic reset_pin, crystal_input_pin, crystal_output_pin, addr_latch_in;
    logic program_fetch_strobe_in;
    int failures = 0, total_checks = 0;
    mpsfr_top DUT (.clk_sys, .resetn, .reg_addr, .reg_indirect, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .bit_write, .bit_index, .bit_value, .ptr_word_write,
        .ptr_word_wdata, .data_address_pointer, .status_wdata, .status_write, .accum_value,
        .irq_pending, .irq_enable, .irq_wake, .timer_tick, .port_pins_in, .port_pins_out,
        .port_pins_oe, .reset_pin, .crystal_input_pin, .crystal_output_pin, .osc_enable,
        .cpu_clock_enable, .periph_clock_enable, .clock_source, .in_circuit_emulation_mode,
        .addr_latch_in, .addr_latch_out, .addr_latch_oe, .addr_latch_weak,
        .program_fetch_strobe_in, .program_fetch_strobe_out, .program_fetch_strobe_oe,
        .program_fetch_strobe_weak, .cpu_ale, .cpu_fetch);
    mpsfr_partner partner (.hw_rst, .emul, .osc_enable, .addr_latch_oe, .addr_latch_out,
        .reset_pin, .crystal_input_pin, .crystal_output_pin, .addr_latch_in,
        .program_fetch_strobe_in);
    always #5 clk_sys = ~clk_sys;
    task cyc(int n); repeat (n) @(posedge clk_sys); endtask : cyc
    task chk(string n, logic [15:0] s, logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value %0s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys); reg_addr <= a; reg_wdata <= d; reg_write <= 1;
        @(posedge clk_sys); reg_write <= 0;
    endtask : wr
    task rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_sys); reg_addr <= a; reg_read <= 1;
        @(posedge clk_sys); reg_read <= 0;
        #1 chk("rdata", reg_rdata, e);
    endtask : rd
    task hrst; cyc(1); hw_rst <= 1; cyc(5); hw_rst <= 0; cyc(5); endtask : hrst
    task t_regs;
        rd(8'h81, 8'h07);
        rd(8'h80, 8'hff);
        wr(8'hff, 8'h5a); rd(8'hff, 8'h00);
        cyc(1); reg_indirect <= 1; wr(8'h85, 8'h66); rd(8'h85, 8'h66);
        cyc(1); reg_indirect <= 0; rd(8'h85, 8'h00);
        cyc(1); port_pins_in[15:8] <= 8'h3c; cyc(4); rd(8'h90, 8'h3c);
        cyc(1); accum_value <= 8'h07; wr(8'hd0, 8'h18); rd(8'hd0, 8'h19);
        cyc(1); bit_write <= 1; reg_addr <= 8'hb8; bit_index <= 3'h4; bit_value <= 1;
        cyc(1); bit_write <= 0; rd(8'hb8, 8'h10);
        wr(8'hb8, 8'h0b); rd(8'hb8, 8'h0b);
        cyc(1); timer_tick <= 2'h1; cyc(1); timer_tick <= 0; rd(8'h8a, 8'h01);
        $display("test regs done");
    endtask : t_regs
    task t_ptr;
        cyc(1); ptr_word_write <= 1; ptr_word_wdata <= 16'h1234; cyc(1); ptr_word_write <= 0;
        rd(8'h82, 8'h34); rd(8'h83, 8'h12);
        wr(8'h82, 8'hab); #1 chk("pointer", data_address_pointer, 16'h12ab);
        $display("test pointer done");
    endtask : t_ptr
    task t_pow;
        wr(8'h87, 8'h01); cyc(3);
        chk("cpu clk", cpu_clock_enable, 0); chk("per clk", periph_clock_enable, 1);
        chk("strobe", addr_latch_out, 1);
        irq_enable <= 5'h01; irq_pending <= 5'h01; cyc(1); #1 chk("wake", irq_wake, 1);
        cyc(2); rd(8'h87, 8'h00); irq_pending <= 0;
        wr(8'h87, 8'h01); hrst; chk("cpu clk", cpu_clock_enable, 1);
        wr(8'h2a, 8'ha5); wr(8'h87, 8'h03); cyc(2);
        chk("osc", osc_enable, 0);
        chk("ale", addr_latch_out, 0); chk("fetch", program_fetch_strobe_out, 0);
        chk("p1 out", port_pins_out[15:8], 8'h3c);
        hrst; rd(8'h87, 8'h00); rd(8'h2a, 8'ha5);
        #1 chk("source", clock_source, crystal_input_pin);
        $display("test power done");
    endtask : t_pow
    task t_emul;
        emul <= 1; hrst; emul <= 0; cyc(2);
        chk("emul", in_circuit_emulation_mode, 1);
        chk("p0 oe", port_pins_oe[7:0], 8'h00); chk("weak", addr_latch_weak, 1);
        chk("ale oe", addr_latch_oe, 0); chk("fetch weak", program_fetch_strobe_weak, 1);
        hrst; chk("emul", in_circuit_emulation_mode, 0);
        $display("test emulation done");
    endtask : t_emul
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin #200000; failures++; end_sim; end
    initial begin
        cyc(20); resetn <= 1;
        t_regs; t_ptr; t_pow; t_emul;
        end_sim;
    end
endmodule : testbench
`default_nettype wire
